// ### design/cpsc_map.svh
// Offsets, field positions and fixed values of the capability check block
`ifndef CPSC_MAP_SVH
`define CPSC_MAP_SVH

// ==========================================================================
// Register byte offsets
`define CPSC_OFF_PERM_MASK   8'h00
`define CPSC_OFF_PERM_RES    8'h04
`define CPSC_OFF_ROOT_SEL    8'h08
`define CPSC_OFF_ROOT_PERM   8'h0c
`define CPSC_OFF_JUMP_CTRL   8'h10
`define CPSC_OFF_JUMP_STAT   8'h14
`define CPSC_OFF_EXP_REQ     8'h18
`define CPSC_OFF_EXP_STAT    8'h1c
`define CPSC_OFF_ADDR_BASE   8'h20
`define CPSC_OFF_ADDR_TOP    8'h24
`define CPSC_OFF_ADDR_CUR    8'h28
`define CPSC_OFF_ADDR_STAT   8'h2c
`define CPSC_OFF_PCREL_IMM   8'h30
`define CPSC_OFF_PCREL_RES   8'h34
`define CPSC_OFF_PARAMS      8'h38

// ==========================================================================
// Permission bit positions
`define CPSC_P_READ          0
`define CPSC_P_WRITE         1
`define CPSC_P_CAP           2
`define CPSC_P_LOAD_MUT      3
`define CPSC_P_LOAD_GLB      4
`define CPSC_P_STORE_LOC     5
`define CPSC_P_EXEC          6
`define CPSC_P_SYSREG        7
`define CPSC_P_USER_SW       8
`define CPSC_P_SEAL          9
`define CPSC_P_UNSEAL        10

// ==========================================================================
// Root permission sets
`define CPSC_ROOT_EXEC_PERMS 11'h0dd
`define CPSC_ROOT_DATA_PERMS 11'h03f
`define CPSC_ROOT_SEAL_PERMS 11'h700
`define CPSC_ROOT_SEL_EXEC   2'h0
`define CPSC_ROOT_SEL_DATA   2'h1
`define CPSC_ROOT_SEL_SEAL   2'h2

// ==========================================================================
// Compressed permission formats
`define CPSC_FMT_SEALING     2'h0
`define CPSC_FMT_EXEC        2'h1
`define CPSC_FMT_CAP_RW      2'h3
`define CPSC_FMT_CAP_RO      3'h5
`define CPSC_FMT_DATA        3'h4
`define CPSC_CODE_CAP_WO     5'h10

// ==========================================================================
// Jump selectors and type values
`define CPSC_REG_NULL        5'h00
`define CPSC_REG_RA          5'h01
`define CPSC_TYPE_UNSEALED   4'h0
`define CPSC_TYPE_SENTRY_LO  4'h1
`define CPSC_TYPE_FWD_HI     4'h3
`define CPSC_TYPE_BWD_LO     4'h4
`define CPSC_TYPE_BWD_HI     4'h5
`define CPSC_TYPE_NONX_BIAS  4'h8
`define CPSC_JC_RS1_LSB      0
`define CPSC_JC_RD_LSB       5
`define CPSC_JC_CT_LSB       10
`define CPSC_JC_TAG          13
`define CPSC_JC_EXEC         14
`define CPSC_JC_BWD_SEL      15

// ==========================================================================
// Base parameters
`define CPSC_MANTISSA_WIDTH  5'd9
`define CPSC_EXP_LIMIT       5'd14
`define CPSC_EXP_MAX         5'd24
`define CPSC_EXP_FIELD_MAX   4'hf
`define CPSC_PCREL_SHIFT     5'd11
`define CPSC_SW_PERM_COUNT   2'd1
`define CPSC_OOB_TAG_KEPT    1'b0
`define CPSC_PERM_COMPRESSED 1'b1
`define CPSC_BOUND_BITS      5'd18
`define CPSC_BOUND_BITS_GAIN 5'd2

`endif

// ### design/cpsc_pkg.sv
// Types shared by the capability check block
package cpsc_pkg;

  typedef logic [10:0] cpsc_perm_t;
  typedef logic [4:0]  cpsc_code_t;
  typedef logic [3:0]  cpsc_type_t;

  typedef enum logic [1:0] {
    CPSC_JUMP_CALL,
    CPSC_JUMP_RETURN,
    CPSC_JUMP_OTHER
  } cpsc_jump_kind_t;

endpackage

// ### design/cpsc_perm_legal.sv
// Permission legaliser: compressed encode and decode in one step
`timescale 1ns/1ns
`default_nettype none
`include "cpsc_map.svh"

module cpsc_perm_legal
  import cpsc_pkg::*;
(
  input  wire cpsc_perm_t req_perms,
  output cpsc_perm_t      legal_perms,
  output cpsc_code_t      perm_code
);

  logic r;
  logic w;
  logic c;

  assign r = req_perms[`CPSC_P_READ];
  assign w = req_perms[`CPSC_P_WRITE];
  assign c = req_perms[`CPSC_P_CAP];

  // ========================================================================
  // Encode: first matching format wins, unrepresentable bits drop
  always_comb
  begin
    if (req_perms[`CPSC_P_EXEC] && r && c)
      perm_code = {`CPSC_FMT_EXEC, req_perms[`CPSC_P_SYSREG],
                   req_perms[`CPSC_P_LOAD_MUT], req_perms[`CPSC_P_LOAD_GLB]};
    else if (r && w && c)
      perm_code = {`CPSC_FMT_CAP_RW, req_perms[`CPSC_P_STORE_LOC],
                   req_perms[`CPSC_P_LOAD_MUT], req_perms[`CPSC_P_LOAD_GLB]};
    else if (r && c)
      perm_code = {`CPSC_FMT_CAP_RO, req_perms[`CPSC_P_LOAD_MUT],
                   req_perms[`CPSC_P_LOAD_GLB]};
    else if (w && c)
      perm_code = `CPSC_CODE_CAP_WO;
    else if (r || w)
      perm_code = {`CPSC_FMT_DATA, r, w};
    else
      perm_code = {`CPSC_FMT_SEALING, req_perms[`CPSC_P_USER_SW],
                   req_perms[`CPSC_P_SEAL], req_perms[`CPSC_P_UNSEAL]};
  end

  // ========================================================================
  // Decode the compressed code back into the granted set
  always_comb
  begin
    legal_perms = '0;
    unique case (perm_code[4:3])
      `CPSC_FMT_SEALING:
      begin
        legal_perms[`CPSC_P_USER_SW] = perm_code[2];
        legal_perms[`CPSC_P_SEAL]    = perm_code[1];
        legal_perms[`CPSC_P_UNSEAL]  = perm_code[0];
      end
      `CPSC_FMT_EXEC:
      begin
        legal_perms[`CPSC_P_READ]     = 1'b1;
        legal_perms[`CPSC_P_CAP]      = 1'b1;
        legal_perms[`CPSC_P_EXEC]     = 1'b1;
        legal_perms[`CPSC_P_SYSREG]   = perm_code[2];
        legal_perms[`CPSC_P_LOAD_MUT] = perm_code[1];
        legal_perms[`CPSC_P_LOAD_GLB] = perm_code[0];
      end
      2'h2:
      begin
        if (perm_code[2])
        begin
          legal_perms[`CPSC_P_READ]     = 1'b1;
          legal_perms[`CPSC_P_CAP]      = 1'b1;
          legal_perms[`CPSC_P_LOAD_MUT] = perm_code[1];
          legal_perms[`CPSC_P_LOAD_GLB] = perm_code[0];
        end
        else if (perm_code[1:0] == 2'h0)
        begin
          legal_perms[`CPSC_P_WRITE] = 1'b1;
          legal_perms[`CPSC_P_CAP]   = 1'b1;
        end
        else
        begin
          legal_perms[`CPSC_P_READ]  = perm_code[1];
          legal_perms[`CPSC_P_WRITE] = perm_code[0];
        end
      end
      `CPSC_FMT_CAP_RW:
      begin
        legal_perms[`CPSC_P_READ]      = 1'b1;
        legal_perms[`CPSC_P_WRITE]     = 1'b1;
        legal_perms[`CPSC_P_CAP]       = 1'b1;
        legal_perms[`CPSC_P_STORE_LOC] = perm_code[2];
        legal_perms[`CPSC_P_LOAD_MUT]  = perm_code[1];
        legal_perms[`CPSC_P_LOAD_GLB]  = perm_code[0];
      end
    endcase
  end

endmodule
`default_nettype wire

// ### design/cpsc_check.sv
// Capability permission, sentry and jump check block with an APB slave
//
// Functional notes
// - Exactly one software-defined user permission, held only by sealing-format capabilities.
// - Three tagged, unsealed, global, full-range roots: executable, data, sealing.
// - No result grants execute with store, or seal/unseal/user with load/store.
// - Execute needs capability access and load; store-local needs load.
// - Permissions are kept in a compressed five-bit representation.
// - Types 1 to 5 are sentries, accepted by the indirect jump and unsealed.
// - A link written to the return-address register is sealed as type 4 or 5.
// - A link written to any other register stays unsealed.
// - Target types allowed depend on the source and destination selectors.
// - A prohibited pairing clears the tag of the new program counter.
// - Sentry meaning exists only on executable capabilities.
// - Bounds use a 9-bit mantissa, exponents 0 to 14 plus 24.
// - Moving the address outside bounds, except one past the end, clears the tag.
// - The PC-relative upper-immediate shift is 11 bit positions.
// - Exponent field cannot hold 15 to 23, so large sizes get coarse bounds.
// - The compact encoding spends two more bits on bounds than before.
`timescale 1ns/1ns
`default_nettype none
`include "cpsc_map.svh"

module cpsc_check
  import cpsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ========================================================================
  // Software-written state
  cpsc_perm_t  perm_mask_reg;
  cpsc_perm_t  perm_mask_next;
  logic [1:0]  root_sel_reg;
  logic [1:0]  root_sel_next;
  logic [15:0] jump_ctrl_reg;
  logic [15:0] jump_ctrl_next;
  logic [4:0]  exp_req_reg;
  logic [4:0]  exp_req_next;
  logic [31:0] addr_base_reg;
  logic [31:0] addr_base_next;
  logic [31:0] addr_top_reg;
  logic [31:0] addr_top_next;
  logic [31:0] addr_cur_reg;
  logic [31:0] addr_cur_next;
  logic [20:0] pcrel_imm_reg;
  logic [20:0] pcrel_imm_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // ========================================================================
  // Block state shown to software
  logic [15:0] perm_res_reg;
  logic [15:0] perm_res_next;
  logic [12:0] jump_stat_reg;
  logic [12:0] jump_stat_next;
  logic [9:0]  exp_stat_reg;
  logic [9:0]  exp_stat_next;
  logic        addr_tag_reg;
  logic        addr_tag_next;

  // ========================================================================
  // Combinational working signals
  logic            wr_en;
  logic            rd_setup;
  logic            addr_hit;
  cpsc_perm_t      root_perms;
  cpsc_perm_t      legal_perms;
  cpsc_code_t      perm_code;
  logic [4:0]      j_rs1;
  logic [4:0]      j_rd;
  logic [2:0]      j_ct;
  logic            j_exec;
  cpsc_type_t      tgt_type;
  cpsc_jump_kind_t jump_kind;
  logic            type_ok;
  logic            is_sentry;
  cpsc_type_t      link_type;
  logic [3:0]      exp_field;
  logic [4:0]      exp_dec;

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  // ========================================================================
  // Address decode
  always_comb
  begin
    unique case (paddr)
      `CPSC_OFF_PERM_MASK, `CPSC_OFF_PERM_RES, `CPSC_OFF_ROOT_SEL,
      `CPSC_OFF_ROOT_PERM, `CPSC_OFF_JUMP_CTRL, `CPSC_OFF_JUMP_STAT,
      `CPSC_OFF_EXP_REQ, `CPSC_OFF_EXP_STAT, `CPSC_OFF_ADDR_BASE,
      `CPSC_OFF_ADDR_TOP, `CPSC_OFF_ADDR_CUR, `CPSC_OFF_ADDR_STAT,
      `CPSC_OFF_PCREL_IMM, `CPSC_OFF_PCREL_RES, `CPSC_OFF_PARAMS:
        addr_hit = 1'b1;
      default:
        addr_hit = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata  = prdata_reg;

  // ========================================================================
  // Roots and permission restriction
  always_comb
  begin
    unique case (root_sel_reg)
      `CPSC_ROOT_SEL_EXEC: root_perms = `CPSC_ROOT_EXEC_PERMS;
      `CPSC_ROOT_SEL_DATA: root_perms = `CPSC_ROOT_DATA_PERMS;
      `CPSC_ROOT_SEL_SEAL: root_perms = `CPSC_ROOT_SEAL_PERMS;
      default:             root_perms = '0;
    endcase
  end

  // Narrowed set is legalised and compressed in a single pass
  cpsc_perm_legal u_legal (
    .req_perms   (root_perms & perm_mask_reg),
    .legal_perms (legal_perms),
    .perm_code   (perm_code)
  );

  // ========================================================================
  // Indirect jump selector and sentry check
  assign j_rs1  = jump_ctrl_reg[`CPSC_JC_RS1_LSB +: 5];
  assign j_rd   = jump_ctrl_reg[`CPSC_JC_RD_LSB +: 5];
  assign j_ct   = jump_ctrl_reg[`CPSC_JC_CT_LSB +: 3];
  assign j_exec = jump_ctrl_reg[`CPSC_JC_EXEC];

  // Non-executable sealed types decode above the sentry range
  always_comb
  begin
    if (j_exec || j_ct == 3'h0)
      tgt_type = {1'b0, j_ct};
    else
      tgt_type = 4'({1'b0, j_ct} + `CPSC_TYPE_NONX_BIAS);
  end

  always_comb
  begin
    if (j_rd == `CPSC_REG_RA)
      jump_kind = CPSC_JUMP_CALL;
    else if (j_rs1 == `CPSC_REG_RA && j_rd == `CPSC_REG_NULL)
      jump_kind = CPSC_JUMP_RETURN;
    else
      jump_kind = CPSC_JUMP_OTHER;
  end

  always_comb
  begin
    type_ok = 1'b0;
    unique case (jump_kind)
      CPSC_JUMP_CALL:
        type_ok = tgt_type <= `CPSC_TYPE_FWD_HI;
      CPSC_JUMP_RETURN:
        type_ok = tgt_type >= `CPSC_TYPE_BWD_LO &&
                  tgt_type <= `CPSC_TYPE_BWD_HI;
      CPSC_JUMP_OTHER:
        type_ok = tgt_type <= `CPSC_TYPE_SENTRY_LO;
    endcase
  end

  assign is_sentry = tgt_type >= `CPSC_TYPE_SENTRY_LO &&
                     tgt_type <= `CPSC_TYPE_BWD_HI;

  // Return link sealing picks the backward type from privileged state
  always_comb
  begin
    if (j_rd != `CPSC_REG_RA)
      link_type = `CPSC_TYPE_UNSEALED;
    else if (jump_ctrl_reg[`CPSC_JC_BWD_SEL])
      link_type = `CPSC_TYPE_BWD_HI;
    else
      link_type = `CPSC_TYPE_BWD_LO;
  end

  // ========================================================================
  // Exponent representation
  always_comb
  begin
    if (exp_req_reg <= `CPSC_EXP_LIMIT)
    begin
      exp_field = exp_req_reg[3:0];
      exp_dec   = exp_req_reg;
    end
    else
    begin
      exp_field = `CPSC_EXP_FIELD_MAX;
      exp_dec   = `CPSC_EXP_MAX;
    end
  end

  // ========================================================================
  // Next-state computation
  always_comb
  begin
    perm_mask_next = perm_mask_reg;
    root_sel_next  = root_sel_reg;
    jump_ctrl_next = jump_ctrl_reg;
    exp_req_next   = exp_req_reg;
    addr_base_next = addr_base_reg;
    addr_top_next  = addr_top_reg;
    addr_cur_next  = addr_cur_reg;
    pcrel_imm_next = pcrel_imm_reg;
    prdata_next    = prdata_reg;

    if (wr_en)
    begin
      unique case (paddr)
        `CPSC_OFF_PERM_MASK:  perm_mask_next = pwdata[10:0];
        `CPSC_OFF_ROOT_SEL:   root_sel_next  = pwdata[1:0];
        `CPSC_OFF_JUMP_CTRL:  jump_ctrl_next = pwdata[15:0];
        `CPSC_OFF_EXP_REQ:    exp_req_next   = pwdata[4:0];
        `CPSC_OFF_ADDR_BASE:  addr_base_next = pwdata;
        `CPSC_OFF_ADDR_TOP:   addr_top_next  = pwdata;
        `CPSC_OFF_ADDR_CUR:   addr_cur_next  = pwdata;
        `CPSC_OFF_PCREL_IMM:  pcrel_imm_next = pwdata[20:0];
        default:              ;
      endcase
    end

    if (rd_setup)
    begin
      unique case (paddr)
        `CPSC_OFF_PERM_MASK:  prdata_next = {21'h0, perm_mask_reg};
        `CPSC_OFF_PERM_RES:   prdata_next = {16'h0, perm_res_reg};
        `CPSC_OFF_ROOT_SEL:   prdata_next = {30'h0, root_sel_reg};
        `CPSC_OFF_ROOT_PERM:
          prdata_next = {2'h3, 16'h0, 3'h0, root_perms};
        `CPSC_OFF_JUMP_CTRL:  prdata_next = {16'h0, jump_ctrl_reg};
        `CPSC_OFF_JUMP_STAT:  prdata_next = {19'h0, jump_stat_reg};
        `CPSC_OFF_EXP_REQ:    prdata_next = {27'h0, exp_req_reg};
        `CPSC_OFF_EXP_STAT:   prdata_next = {22'h0, exp_stat_reg};
        `CPSC_OFF_ADDR_BASE:  prdata_next = addr_base_reg;
        `CPSC_OFF_ADDR_TOP:   prdata_next = addr_top_reg;
        `CPSC_OFF_ADDR_CUR:   prdata_next = addr_cur_reg;
        `CPSC_OFF_ADDR_STAT:  prdata_next = {31'h0, addr_tag_reg};
        `CPSC_OFF_PCREL_IMM:  prdata_next = {11'h0, pcrel_imm_reg};
        `CPSC_OFF_PCREL_RES:
          prdata_next = 32'({11'h0, pcrel_imm_reg} << `CPSC_PCREL_SHIFT);
        `CPSC_OFF_PARAMS:
          prdata_next = {3'h0, `CPSC_BOUND_BITS_GAIN,
                         `CPSC_BOUND_BITS,
                         `CPSC_PERM_COMPRESSED, `CPSC_OOB_TAG_KEPT,
                         `CPSC_SW_PERM_COUNT, `CPSC_PCREL_SHIFT,
                         `CPSC_EXP_MAX, `CPSC_MANTISSA_WIDTH};
        default:              prdata_next = 32'h0;
      endcase
    end

    // Status follows the written controls one cycle later
    perm_res_next = {perm_code, legal_perms};
    jump_stat_next = {1'b0, link_type != `CPSC_TYPE_UNSEALED, link_type,
                      is_sentry && type_ok,
                      jump_ctrl_reg[`CPSC_JC_TAG] && type_ok,
                      type_ok, tgt_type};
    exp_stat_next = {exp_req_reg > `CPSC_EXP_LIMIT, exp_field, exp_dec};
    // One past the end keeps the tag, anything further out loses it
    addr_tag_next = addr_cur_reg >= addr_base_reg &&
                    addr_cur_reg <= addr_top_reg;
  end

  // ========================================================================
  // State registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      perm_mask_reg <= '0;
      root_sel_reg  <= `CPSC_ROOT_SEL_EXEC;
      jump_ctrl_reg <= 16'h0;
      exp_req_reg   <= 5'h0;
      addr_base_reg <= 32'h0;
      addr_top_reg  <= 32'h0;
      addr_cur_reg  <= 32'h0;
      pcrel_imm_reg <= 21'h0;
      prdata_reg    <= 32'h0;
      perm_res_reg  <= 16'h0;
      jump_stat_reg <= 13'h0;
      exp_stat_reg  <= 10'h0;
      addr_tag_reg  <= 1'b0;
    end
    else
    begin
      perm_mask_reg <= perm_mask_next;
      root_sel_reg  <= root_sel_next;
      jump_ctrl_reg <= jump_ctrl_next;
      exp_req_reg   <= exp_req_next;
      addr_base_reg <= addr_base_next;
      addr_top_reg  <= addr_top_next;
      addr_cur_reg  <= addr_cur_next;
      pcrel_imm_reg <= pcrel_imm_next;
      prdata_reg    <= prdata_next;
      perm_res_reg  <= perm_res_next;
      jump_stat_reg <= jump_stat_next;
      exp_stat_reg  <= exp_stat_next;
      addr_tag_reg  <= addr_tag_next;
    end
  end

endmodule
`default_nettype wire

// ### test/cpsc_check_monitor.sv
// Concurrent checks on the APB ports of the capability check block
`timescale 1ns/1ns
`default_nettype none

module cpsc_check_monitor (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic rd_su;
  logic bad;

  assign rd_su = psel && !penable && !pwrite;
  assign bad   = paddr[1:0] != 2'h0 || paddr > 8'h38;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ========================================================================
  // Bus behaviour
  err_flag_a: assert property (pslverr == (psel && penable && bad))
    else $error("error flag wrong");
  rdata_hold_a: assert property (!rd_su |=> $stable(prdata))
    else $error("read data moved outside a read setup");
  rst_clear_a: assert property ($fell(sys_rst) |-> prdata == 32'h0)
    else $error("read data not cleared by reset");
  ready_high_a: assert property (psel && penable |-> pready)
    else $error("ready low in access phase");

  // ========================================================================
  // Computed status words
  params_word_a:
    assert property (rd_su && paddr == 8'h38 |=> prdata == 32'h0294af09)
    else $error("parameter word wrong");
  root_word_a:
    assert property (rd_su && paddr == 8'h0c |=> prdata[31:11] == 21'h180000
      && prdata[10:0] inside {11'h0dd, 11'h03f, 11'h700, 11'h000})
    else $error("root word wrong");
  perm_legal_a:
    assert property (rd_su && paddr == 8'h04 |=> !(prdata[6] && prdata[1])
      && !((prdata[8] || prdata[9] || prdata[10]) && (prdata[0] || prdata[1]))
      && (!prdata[6] || (prdata[2] && prdata[0])) && (!prdata[5] || prdata[0]))
    else $error("illegal permission set");
  link_seal_a:
    assert property (rd_su && paddr == 8'h14 |=>
      prdata[11] == (prdata[10:7] == 4'h4 || prdata[10:7] == 4'h5))
    else $error("link sealing wrong");
  jump_permit_a:
    assert property (rd_su && paddr == 8'h14 |=> (!prdata[5] || prdata[4])
      && (!prdata[6] || (prdata[4] && prdata[3:0] inside {[4'h1:4'h5]}))
      && (!prdata[4] || prdata[3:0] <= 4'h5))
    else $error("jump permit wrong");
  exp_stat_a:
    assert property (rd_su && paddr == 8'h1c |=> (prdata[9] ?
      prdata[8:0] == 9'h1f8 :
      prdata[4:0] <= 5'd14 && prdata[8:5] == prdata[3:0]))
    else $error("exponent status wrong");
  pcrel_low_a:
    assert property (rd_su && paddr == 8'h34 |=> prdata[10:0] == 11'h0)
    else $error("shifted immediate low bits set");

  cover property (rd_su && paddr == 8'h14);
  cover property (psel && penable && pslverr);
  cover property (psel && penable && pwrite && paddr == 8'h04);
  cover property (psel && penable && pwrite && paddr == 8'h10 && pwdata[14]);
endmodule

bind cpsc_check cpsc_check_monitor mon_u (
  .ref_clk (ref_clk),
  .sys_rst (sys_rst),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .paddr   (paddr),
  .pwdata  (pwdata),
  .prdata  (prdata),
  .pready  (pready),
  .pslverr (pslverr)
);

`default_nettype wire

// ### test/tb_cpsc_check.sv
// Self-checking bench for the capability check block
`timescale 1ns/1ns
`default_nettype none

module tb_cpsc_check
  import cpsc_pkg::*;
;
  logic        ref_clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_errors;
  int          comparisons;
  logic [31:0] seed;
  logic [31:0] r;
  logic [31:0] d;
  logic [31:0] regs [0:15];

  cpsc_check dut_u (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // ========================================================================
  // Reference model
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [10:0] root(input logic [1:0] s);
    case (s)
      2'h0: root = 11'h0dd;
      2'h1: root = 11'h03f;
      2'h2: root = 11'h700;
      default: root = 11'h000;
    endcase
  endfunction

  // First matching format wins; bits it cannot hold are dropped
  function automatic logic [15:0] legal(input logic [10:0] p);
    if (p[6] && p[0] && p[2]) legal = {2'b01, p[7], p[3], p[4], p & 11'h0dd};
    else if (p[0] && p[1] && p[2])
      legal = {2'b11, p[5], p[3], p[4], p & 11'h03f};
    else if (p[0] && p[2]) legal = {3'b101, p[3], p[4], p & 11'h01d};
    else if (p[1] && p[2]) legal = {5'h10, p & 11'h006};
    else if (p[0] || p[1]) legal = {3'b100, p[0], p[1], p & 11'h003};
    else legal = {2'b00, p[8], p[9], p[10], p & 11'h700};
  endfunction

  function automatic logic [11:0] jump(input logic [15:0] c);
    logic [3:0] t;
    logic       ok;
    logic       ra;
    ra = c[9:5] == 5'h01;
    t = {1'b0, c[12:10]} + ((c[14] || c[12:10] == 3'h0) ? 4'h0 : 4'h8);
    if (ra) ok = t <= 4'h3;
    else if (c[4:0] == 5'h01 && c[9:5] == 5'h00) ok = t == 4'h4 || t == 4'h5;
    else ok = t <= 4'h1;
    jump = {ra, ra ? {3'b010, c[15]} : 4'h0, ok && t >= 4'h1 && t <= 4'h5,
            c[13] && ok, ok, t};
  endfunction

  function automatic logic [31:0] wm(input logic [7:0] a);
    case (a)
      8'h00: wm = 32'h7ff;
      8'h08: wm = 32'h3;
      8'h10: wm = 32'hffff;
      8'h18: wm = 32'h1f;
      8'h20, 8'h24, 8'h28: wm = 32'hffffffff;
      8'h30: wm = 32'h1fffff;
      default: wm = 32'h0;
    endcase
  endfunction

  function automatic logic [31:0] model(input logic [7:0] a);
    case (a)
      8'h04: model = {16'h0, legal(root(regs[2][1:0]) & regs[0][10:0])};
      8'h0c: model = {2'b11, 19'h0, root(regs[2][1:0])};
      8'h14: model = {20'h0, jump(regs[4][15:0])};
      8'h1c: model = regs[6] > 32'd14 ? 32'h3f8 :
                     {23'h0, regs[6][3:0], regs[6][4:0]};
      8'h2c: model = {31'h0, regs[8] <= regs[10] && regs[10] <= regs[9]};
      8'h34: model = regs[12] << 11;
      8'h38: model = 32'h0294af09;
      default: model = (a[1:0] == 2'h0 && a <= 8'h38) ? regs[a[5:2]] : 32'h0;
    endcase
  endfunction

  // ========================================================================
  // Bus tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    if (w && wm(a) != 32'h0) regs[a[5:2]] = v & wm(a);
    chk("pready", 32'h1, {31'h0, pready});
    chk("pslverr", {31'h0, !(a[1:0] == 2'h0 && a <= 8'h38)}, {31'h0, pslverr});
    if (!w) chk("prdata", model(a), prdata);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input int cyc);
    sys_rst <= 1'b1;
    repeat (cyc) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (regs[i]) regs[i] = 32'h0;
  endtask

  task automatic scan();
    for (int a = 0; a < 72; a += 4) op(1'b0, 8'(a), 32'h0);
    op(1'b0, 8'h02, 32'h0);
  endtask

  task automatic stop_test();
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [4:0] sel5(input int k);
    logic [31:0] q;
    q = xs();
    sel5 = k == 0 ? 5'h00 : k == 1 ? 5'h01 : q[4:0] | 5'h02;
  endfunction

  // ========================================================================
  // Stimulus
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    stop_test();
  end

  initial
  begin
    seed = 32'h1b860f56;
    n_errors = 0;
    comparisons = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    do_reset(6);
    scan();
    for (int i = 0; i < 64; i++)
    begin
      op(1'b1, 8'h08, 32'(i));
      op(1'b1, 8'h00, i < 4 ? 32'h7ff : xs());
      op(1'b0, 8'h0c, 32'h0);
      op(1'b0, 8'h04, 32'h0);
    end
    for (int i = 0; i < 144; i++)
    begin
      r = xs();
      d = {16'h0, r[1], 1'(i / 72), r[0], 3'(i / 9), sel5(i / 3 % 3),
           sel5(i % 3)};
      op(1'b1, 8'h10, d);
      op(1'b0, 8'h14, 32'h0);
    end
    for (int i = 0; i < 32; i++)
    begin
      op(1'b1, 8'h18, 32'(i));
      op(1'b0, 8'h1c, 32'h0);
    end
    for (int i = 0; i < 24; i++)
    begin
      r = xs();
      op(1'b1, 8'h20, r);
      op(1'b1, 8'h24, r + 32'(i * 8));
      op(1'b1, 8'h28, r + 32'(i * 8 + i % 3) - 32'h1);
      op(1'b0, 8'h2c, 32'h0);
    end
    for (int i = 0; i < 8; i++)
    begin
      op(1'b1, 8'h30, i == 0 ? 32'hffffffff : xs());
      op(1'b0, 8'h34, 32'h0);
    end
    for (int i = 0; i < 200; i++)
    begin
      r = xs();
      op(r[31], {1'b0, r[9] & r[10], r[5:2], r[1:0] & {2{r[11]}}}, xs());
    end
    do_reset(2);
    scan();
    stop_test();
  end
endmodule

`default_nettype wire
